/* core/ctl_locator.sv */
`timescale 1ns/1ps
module ctl_locator (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   ctl_if.dev        lnk,
   output logic      o_tip_update,
   output logic      o_tip_found
);

   // ***********************************************
   // state
   // ***********************************************
   // only scalars are kept: no pixel is stored
   ctl_pkg::ctl_coord_t x_pos_q;
   ctl_pkg::ctl_coord_t y_pos_q;
   ctl_pkg::ctl_coord_t dark_run_count_q;
   ctl_pkg::ctl_coord_t run_start_q;
   logic                row_hit_q;
   logic                run_open_q;
   ctl_pkg::ctl_coord_t hit_start_q;
   ctl_pkg::ctl_coord_t hit_stop_q;
   ctl_pkg::ctl_coord_t min_run_start_q;
   ctl_pkg::ctl_coord_t min_y_q;
   ctl_pkg::ctl_coord_t max_run_end_q;
   ctl_pkg::ctl_coord_t max_y_q;
   logic                first_row_q;
   logic                prev_hit_q;
   ctl_pkg::ctl_coord_t prev_start_q;
   logic                tb_found_q;
   ctl_pkg::ctl_coord_t tb_x_q;
   ctl_pkg::ctl_coord_t tb_y_q;
   ctl_pkg::ctl_coord_t tip_x_q;
   ctl_pkg::ctl_coord_t tip_y_q;

   // ***********************************************
   // pixel classification
   // ***********************************************
   logic                dark;
   logic                fend;
   logic                rend;
   logic                reg_now;
   logic                side_left;
   logic                side_right;
   ctl_pkg::ctl_coord_t run_next;
   ctl_pkg::ctl_coord_t run_first;

   assign fend      = lnk.frame_end_pulse;
   assign rend      = lnk.row_end_pulse && !fend;
   assign dark      = lnk.green_valid && (lnk.pix_data < lnk.threshold);
   assign run_next  = dark_run_count_q + ctl_pkg::COORD_ONE;
   // start of the run that this pixel extends
   assign run_first = (dark_run_count_q == ctl_pkg::COORD_ZERO) ?
                      x_pos_q : run_start_q;
   // only the first qualifying run of a row is kept
   assign reg_now   = dark && !row_hit_q &&
                      (run_next == ctl_pkg::MIN_DARK_RUN_LENGTH);

   // ***********************************************
   // row position and row count
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         x_pos_q <= ctl_pkg::COORD_ZERO;
      end else if (fend || lnk.row_end_pulse) begin
         x_pos_q <= ctl_pkg::COORD_ZERO;
      end else if (lnk.green_valid) begin
         x_pos_q <= x_pos_q + ctl_pkg::COORD_ONE;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         y_pos_q <= ctl_pkg::COORD_ZERO;
      end else if (fend) begin
         y_pos_q <= ctl_pkg::COORD_ZERO;
      end else if (rend) begin
         y_pos_q <= y_pos_q + ctl_pkg::COORD_ONE;
      end
   end

   // ***********************************************
   // dark run tracking
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dark_run_count_q <= ctl_pkg::COORD_ZERO;
         run_start_q      <= ctl_pkg::COORD_ZERO;
      end else if (fend || lnk.row_end_pulse) begin
         dark_run_count_q <= ctl_pkg::COORD_ZERO;
      end else if (lnk.green_valid) begin
         if (dark) begin
            dark_run_count_q <= run_next;
            run_start_q      <= run_first;
         end else begin
            // a bright pixel breaks contiguity
            dark_run_count_q <= ctl_pkg::COORD_ZERO;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         row_hit_q   <= 1'b0;
         run_open_q  <= 1'b0;
         hit_start_q <= ctl_pkg::COORD_ZERO;
         hit_stop_q  <= ctl_pkg::COORD_ZERO;
      end else if (fend || lnk.row_end_pulse) begin
         row_hit_q  <= 1'b0;
         run_open_q <= 1'b0;
      end else if (reg_now) begin
         row_hit_q   <= 1'b1;
         run_open_q  <= 1'b1;
         hit_start_q <= run_first;
         hit_stop_q  <= x_pos_q;
      end else if (lnk.green_valid && run_open_q) begin
         if (dark) begin
            hit_stop_q <= x_pos_q;
         end else begin
            run_open_q <= 1'b0;
         end
      end
   end

   // ***********************************************
   // side entry extremes
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         min_run_start_q <= ctl_pkg::X_MIN_INIT;
         min_y_q         <= ctl_pkg::COORD_ZERO;
      end else if (fend) begin
         min_run_start_q <= ctl_pkg::X_MIN_INIT;
         min_y_q         <= ctl_pkg::COORD_ZERO;
      end else if (rend && row_hit_q && (hit_start_q < min_run_start_q)) begin
         min_run_start_q <= hit_start_q;
         min_y_q         <= y_pos_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         max_run_end_q <= ctl_pkg::COORD_ZERO;
         max_y_q       <= ctl_pkg::COORD_ZERO;
      end else if (fend) begin
         max_run_end_q <= ctl_pkg::COORD_ZERO;
         max_y_q       <= ctl_pkg::COORD_ZERO;
      end else if (rend && row_hit_q && (hit_stop_q > max_run_end_q)) begin
         max_run_end_q <= hit_stop_q;
         max_y_q       <= y_pos_q;
      end
   end

   // ***********************************************
   // top and bottom entry: row tags
   // ***********************************************
   // the first row has no predecessor, so it cannot be a change
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         first_row_q  <= 1'b1;
         prev_hit_q   <= 1'b0;
         prev_start_q <= ctl_pkg::COORD_ZERO;
      end else if (fend) begin
         first_row_q  <= 1'b1;
         prev_hit_q   <= 1'b0;
         prev_start_q <= ctl_pkg::COORD_ZERO;
      end else if (rend) begin
         first_row_q  <= 1'b0;
         prev_hit_q   <= row_hit_q;
         prev_start_q <= hit_start_q;
      end
   end

   // the tagged row itself is reported: entering row or last cue row
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tb_found_q <= 1'b0;
         tb_x_q     <= ctl_pkg::COORD_ZERO;
         tb_y_q     <= ctl_pkg::COORD_ZERO;
      end else if (fend) begin
         tb_found_q <= 1'b0;
      end else if (rend && !first_row_q && !tb_found_q &&
                   (row_hit_q != prev_hit_q)) begin
         tb_found_q <= 1'b1;
         if (row_hit_q) begin
            tb_x_q <= hit_start_q;
            tb_y_q <= y_pos_q;
         end else begin
            tb_x_q <= prev_start_q;
            tb_y_q <= y_pos_q - ctl_pkg::COORD_ONE;
         end
      end
   end

   // ***********************************************
   // frame end decision and output latches
   // ***********************************************
   assign side_left  = (min_run_start_q == ctl_pkg::COORD_ZERO);
   assign side_right = (max_run_end_q == ctl_pkg::X_MAX);

   // side entry wins over top/bottom: a side cue also flips tags
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tip_x_q     <= ctl_pkg::COORD_ZERO;
         tip_y_q     <= ctl_pkg::COORD_ZERO;
         o_tip_found <= 1'b0;
      end else if (fend) begin
         o_tip_found <= side_left || side_right || tb_found_q;
         if (side_left) begin
            tip_x_q <= max_run_end_q;
            tip_y_q <= max_y_q;
         end else if (side_right) begin
            tip_x_q <= min_run_start_q;
            tip_y_q <= min_y_q;
         end else if (tb_found_q) begin
            tip_x_q <= tb_x_q;
            tip_y_q <= tb_y_q;
         end
         // otherwise the previous tip stands
      end
   end

   // the tip update flag lands one edge after the frame end pulse
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tip_update <= 1'b0;
      end else begin
         o_tip_update <= fend;
      end
   end

   assign lnk.tip_x = tip_x_q;
   assign lnk.tip_y = tip_y_q;

endmodule

/* inc/ctl_pkg.sv */
package ctl_pkg;

   // ***********************************************
   // widths
   // ***********************************************
   localparam int unsigned PIX_W   = 10;
   localparam int unsigned COORD_W = 16;

   typedef logic [PIX_W-1:0]   ctl_pix_t;
   typedef logic [COORD_W-1:0] ctl_coord_t;

   // ***********************************************
   // geometry and detection constants
   // ***********************************************
   // last green column of a row; plain default
   localparam ctl_coord_t X_MAX               = 16'h013F;
   localparam ctl_coord_t X_MIN_INIT          = 16'h0140;
   localparam ctl_coord_t MIN_DARK_RUN_LENGTH = 16'h0008;
   localparam ctl_coord_t COORD_ZERO          = 16'h0000;
   localparam ctl_coord_t COORD_ONE           = 16'h0001;
   localparam ctl_pix_t   PIX_ZERO            = 10'h000;

endpackage

/* inc/ctl_if.sv */
`timescale 1ns/1ps
interface ctl_if;
   logic [ctl_pkg::PIX_W-1:0]   pix_data;
   logic                        green_valid;
   logic                        row_end_pulse;
   logic                        frame_end_pulse;
   logic [ctl_pkg::PIX_W-1:0]   threshold;
   logic [ctl_pkg::COORD_W-1:0] tip_x;
   logic [ctl_pkg::COORD_W-1:0] tip_y;

   modport dev (
      input  pix_data,
      input  green_valid,
      input  row_end_pulse,
      input  frame_end_pulse,
      input  threshold,
      output tip_x,
      output tip_y
   );

   modport src (
      output pix_data,
      output green_valid,
      output row_end_pulse,
      output frame_end_pulse,
      output threshold,
      input  tip_x,
      input  tip_y
   );
endinterface

/* core/ctl_feeder.sv */
`timescale 1ns/1ps
module ctl_feeder (
   input  wire logic                        i_clk,
   input  wire logic                        i_rstn,
   input  wire logic [ctl_pkg::PIX_W-1:0]   i_pix,
   input  wire logic                        i_pix_strobe,
   input  wire logic                        i_line_done,
   input  wire logic                        i_frame_done,
   input  wire logic [ctl_pkg::PIX_W-1:0]   i_threshold,
   input  wire logic                        i_thr_load,
   ctl_if.src                               lnk,
   output logic [ctl_pkg::COORD_W-1:0]      o_tip_x,
   output logic [ctl_pkg::COORD_W-1:0]      o_tip_y,
   output logic                             o_tip_new
);

   // ***********************************************
   // edge detection of user strobes
   // ***********************************************
   logic                 strobe_q;
   logic                 line_q;
   logic                 frame_q;
   logic                 start_q;
   ctl_pkg::ctl_pix_t    pix_q;
   logic                 valid_q;
   logic                 row_q;
   logic                 fend_q;
   ctl_pkg::ctl_pix_t    thr_q;
   logic                 fend_d;

   // startup needs a frame end of its own
   assign fend_d = start_q || (i_frame_done && !frame_q);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strobe_q <= 1'b0;
         line_q   <= 1'b0;
         frame_q  <= 1'b0;
      end else begin
         strobe_q <= i_pix_strobe;
         line_q   <= i_line_done;
         frame_q  <= i_frame_done;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         start_q <= 1'b1;
      end else begin
         start_q <= 1'b0;
      end
   end

   // ***********************************************
   // pixel and framing pulses
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pix_q   <= ctl_pkg::PIX_ZERO;
         valid_q <= 1'b0;
      end else begin
         valid_q <= i_pix_strobe && !strobe_q;
         if (i_pix_strobe && !strobe_q) begin
            pix_q <= i_pix;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         row_q  <= 1'b0;
         fend_q <= 1'b0;
      end else begin
         row_q  <= i_line_done && !line_q;
         fend_q <= fend_d;
      end
   end

   // ***********************************************
   // threshold: taken at startup or between frames
   // ***********************************************
   // a mid-frame change would split one frame's classification
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         thr_q <= ctl_pkg::PIX_ZERO;
      end else if (start_q || (i_thr_load && fend_d)) begin
         thr_q <= i_threshold;
      end
   end

   assign lnk.pix_data        = pix_q;
   assign lnk.green_valid     = valid_q;
   assign lnk.row_end_pulse   = row_q;
   assign lnk.frame_end_pulse = fend_q;
   assign lnk.threshold       = thr_q;

   // ***********************************************
   // coordinate readback
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tip_x   <= ctl_pkg::COORD_ZERO;
         o_tip_y   <= ctl_pkg::COORD_ZERO;
         o_tip_new <= 1'b0;
      end else begin
         o_tip_x   <= lnk.tip_x;
         o_tip_y   <= lnk.tip_y;
         o_tip_new <= (lnk.tip_x != o_tip_x) || (lnk.tip_y != o_tip_y);
      end
   end

endmodule

/* tb/ctl_link_assertions.sv */
`timescale 1ns/1ps
module ctl_link_assertions (
   input wire logic                        i_clk,
   input wire logic                        i_rstn,
   input wire logic [ctl_pkg::PIX_W-1:0]   pix_data,
   input wire logic                        green_valid,
   input wire logic                        row_end_pulse,
   input wire logic                        frame_end_pulse,
   input wire logic [ctl_pkg::PIX_W-1:0]   threshold,
   input wire logic [ctl_pkg::COORD_W-1:0] tip_x,
   input wire logic [ctl_pkg::COORD_W-1:0] tip_y
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // ************************************
   // link pulses and qualifiers
   // ************************************
   AST_VALID_PULSE: assert property (green_valid |=> !green_valid)
      else $error("green valid wider than one cycle");
   AST_PIX_QUAL: assert property ($changed(pix_data) |-> green_valid)
      else $error("pixel changed without valid");
   AST_ROW_PULSE: assert property (row_end_pulse |=> !row_end_pulse)
      else $error("row end wider than one cycle");
   AST_FRAME_PULSE: assert property (frame_end_pulse |=> !frame_end_pulse)
      else $error("frame end wider than one cycle");
   AST_NO_OVERLAP: assert property (
      green_valid |-> !row_end_pulse && !frame_end_pulse)
      else $error("pixel shares cycle with row or frame end");
   // startup frame end brings the locator to a known state
   AST_STARTUP_END: assert property (
      !$past(i_rstn) |-> ##[1:2] frame_end_pulse)
      else $error("no frame end after reset");
   AST_THR_HOLD: assert property (green_valid |-> $stable(threshold))
      else $error("threshold moved inside a frame");

   // ************************************
   // coordinate outputs
   // ************************************
   AST_TIP_HOLD: assert property (
      !frame_end_pulse |=> $stable(tip_x) && $stable(tip_y))
      else $error("tip moved outside frame end");
   // the min start seed is one past the row and must never leak
   AST_TIP_RANGE: assert property (tip_x <= ctl_pkg::X_MAX)
      else $error("tip x beyond last column");

   COV_FRAME_TIP: cover property (frame_end_pulse ##1 $changed(tip_x));
   COV_DARK: cover property (green_valid && pix_data < threshold);
   COV_ROW: cover property (row_end_pulse ##2 green_valid);
endmodule

/* tb/tb_cue_tip_locator.sv */
`timescale 1ns/1ps
module tb_cue_tip_locator;
   localparam logic [9:0] THR = 10'h200;
   localparam int         W   = 320;
   logic        i_clk        = 1'b0;
   logic        i_rstn       = 1'b0;
   logic [9:0]  i_pix        = 10'h000;
   logic        i_pix_strobe = 1'b0;
   logic        i_line_done  = 1'b0;
   logic        i_frame_done = 1'b0;
   logic [9:0]  i_threshold  = THR;
   logic        i_thr_load   = 1'b0;
   // threshold the locator really holds for the current frame
   logic [9:0]  thr          = THR;
   logic [15:0] o_tip_x;
   logic [15:0] o_tip_y;
   logic        o_tip_new;
   logic        o_tip_update;
   logic        o_tip_found;
   int          mismatches   = 0;
   int          compares     = 0;
   int          cyc          = 0;
   int          px           = 0;
   int          py           = 0;
   int          qs[$];
   int          ql[$];
   int          qn[$];

   ctl_if lnk_if ();
   ctl_feeder ctl_feeder_inst (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_pix(i_pix), .i_pix_strobe(i_pix_strobe),
      .i_line_done(i_line_done), .i_frame_done(i_frame_done),
      .i_threshold(i_threshold), .i_thr_load(i_thr_load), .lnk(lnk_if),
      .o_tip_x(o_tip_x), .o_tip_y(o_tip_y), .o_tip_new(o_tip_new));
   ctl_locator ctl_locator_inst (.i_clk(i_clk), .i_rstn(i_rstn),
      .lnk(lnk_if), .o_tip_update(o_tip_update), .o_tip_found(o_tip_found));
   ctl_link_assertions ctl_link_assertions_inst (.i_clk(i_clk),
      .i_rstn(i_rstn), .pix_data(lnk_if.pix_data),
      .green_valid(lnk_if.green_valid), .row_end_pulse(lnk_if.row_end_pulse),
      .frame_end_pulse(lnk_if.frame_end_pulse),
      .threshold(lnk_if.threshold), .tip_x(lnk_if.tip_x),
      .tip_y(lnk_if.tip_y));

   always #20 i_clk = ~i_clk;

   // ************************************
   // drivers and checks
   // ************************************
   task automatic step();
      @(posedge i_clk);
      #1;
   endtask

   // strobes need a low cycle between edges
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      step();
      sig = 1'b0;
      step();
   endtask

   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask

   task automatic row(int s, int l, int n);
      qs.push_back(s);
      ql.push_back(l);
      qn.push_back(n);
   endtask

   // noise rows darken x 0..6, a run one short of registering
   task automatic frame(string name);
      int   mn, mny, mx, mxy, tc, ex, ey, fnd, rg, prg;
      logic dk;
      mn = W; mny = 0; mx = 0; mxy = 0; tc = -1; ex = px; ey = py; prg = 0;
      foreach (qs[r]) begin
         for (int x = 0; x < W; x++) begin
            dk = (x >= qs[r] && x < qs[r] + ql[r]) || (qn[r] != 0 && x < 7);
            i_pix = dk ? (x[0] ? thr - 10'h001 : 10'($urandom % thr))
                       : (x[0] ? thr : thr | 10'($urandom % 10'h200));
            pulse(i_pix_strobe);
         end
         pulse(i_line_done);
         rg = int'(ql[r] >= 8);
         if (rg != 0 && qs[r] < mn) begin mn = qs[r]; mny = r; end
         if (rg != 0 && qs[r] + ql[r] - 1 > mx) begin
            mx = qs[r] + ql[r] - 1;
            mxy = r;
         end
         if (r > 0 && tc < 0 && rg != prg) begin
            tc = r;
            ex = (rg != 0) ? qs[r] : qs[r-1];
            ey = (rg != 0) ? r : r - 1;
         end
         prg = rg;
      end
      fnd = int'(tc >= 0);
      if (mn == 0) begin ex = mx; ey = mxy; fnd = 1; end
      else if (mx == W - 1) begin ex = mn; ey = mny; fnd = 1; end
      i_thr_load = 1'b1;
      i_frame_done = 1'b1;
      step();
      i_thr_load = 1'b0;
      i_frame_done = 1'b0;
      // a load request only takes effect with a frame end
      thr = i_threshold;
      step();
      for (int i = 0; i < 20 && o_tip_update !== 1'b1; i++) step();
      chk("tip_update", 16'h0001, 16'(o_tip_update));
      chk("tip_found", 16'(fnd), 16'(o_tip_found));
      chk("tip_x", 16'(ex), lnk_if.tip_x);
      chk("tip_y", 16'(ey), lnk_if.tip_y);
      step();
      chk("rd_x", 16'(ex), o_tip_x);
      chk("rd_y", 16'(ey), o_tip_y);
      // change flag rises with the readback copy itself
      chk("tip_new", 16'(ex != px || ey != py), 16'(o_tip_new));
      step();
      chk("tip_new_end", 16'h0000, 16'(o_tip_new));
      px = ex;
      py = ey;
      qs.delete();
      ql.delete();
      qn.delete();
      $display("test %s done", name);
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // about 21k cycles expected; ceiling leaves ample margin
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         $display("[ERR] run exp done seen hang");
         summarize();
      end
   end

   // ************************************
   // scenarios
   // ************************************
   initial begin
      int s;
      int l;
      void'($urandom(32'hBC75));
      repeat (5) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      repeat (4) step();
      row(0, 0, 0); row(0, 40, 0); row(0, 90, 0); row(0, 90, 0);
      row(0, 20, 0);
      frame("left");
      row(250, 70, 0); row(200, 120, 0); row(200, 120, 0); row(300, 5, 1);
      frame("right");
      row(100, 30, 1); row(90, 30, 0); row(313, 7, 0); row(0, 0, 1);
      row(50, 10, 0);
      frame("top");
      row(0, 0, 1); row(0, 0, 0); row(150, 8, 0); row(140, 7, 0);
      frame("bottom");
      row(10, 7, 0); row(0, 0, 1); row(0, 0, 0);
      frame("empty");
      repeat (3) begin
         // held load request must wait for the frame end
         i_threshold = 10'h010 + 10'($urandom % 10'h3F0);
         i_thr_load = 1'b1;
         repeat (4) begin
            s = $urandom % W;
            l = $urandom % 60;
            if (s + l > W) l = W - s;
            row(s, l, (s >= 8) ? $urandom % 2 : 0);
         end
         frame("random");
      end
      summarize();
   end
endmodule
